/* File: logic/acc_top.sv */
// Converter control register file: control, divider and result registers
// reached through the core's special function register port.
// Assumes a one-cycle write strobe and a combinationally decoded read
// returned one cycle later from a flip-flop.
`include "acc_defs.svh"
module acc_top
    import acc_pkg::*;
(
    // Clocking.
    input  wire logic          sys_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    // Special function register port.
    input  wire logic [7:0]    sfr_addr,
    input  wire acc_byte_t     sfr_wdata,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    output acc_byte_t          sfr_rdata,
    // Interrupt enable from the core's interrupt enable register.
    input  wire logic          converter_interrupt_enable,
    // Analog core and CPU core side.
    input  wire acc_result_t   core_result_pin,
    output logic               converter_enable,
    output logic               channel_select,
    output logic               sample_start,
    output logic               cpu_suspend,
    output logic               conversion_irq
);
    import acc_pkg::*;

    acc_seq_if sq ();

    acc_byte_t   ctrl_reg, ctrl_next;
    acc_byte_t   div_reg, div_next;
    acc_result_t res_reg, res_next;
    acc_byte_t   rdata_reg, rdata_next;
    logic        irq_reg, irq_next;
    logic        start_reg, start_next;
    logic        suspend_reg, suspend_next;
    acc_result_t sync1_reg, sync2_reg;
    logic        running;

    // Address decode shared by reads and writes.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    assign running = ctrl_reg[`ACC_BIT_START];

    // Two-flop synchroniser for the analog result lines.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en) begin
            sync1_reg <= core_result_pin;
            sync2_reg <= sync1_reg;
        end
    end

    acc_seq u_seq (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .clk_en      (clk_en),
        .sq          (sq.seq),
        .core_result (sync2_reg)
    );

    assign sq.divider = div_reg[4:0];
    assign sq.launch  = start_reg;

    // Register writes, hardware clears and the completion set.
    always_comb begin
        ctrl_next  = ctrl_reg;
        div_next   = div_reg;
        res_next   = res_reg;
        start_next = 1'b0;
        if (sfr_wr && hit(sfr_addr, `ACC_OFS_CONTROL)) begin
            // Reserved bits are masked so they always read zero.
            ctrl_next = sfr_wdata & `ACC_CTRL_MASK;
            if (running) begin
                ctrl_next[`ACC_BIT_START] = 1'b1;
                ctrl_next[`ACC_BIT_IDLE]  = ctrl_reg[`ACC_BIT_IDLE];
            end else if (sfr_wdata[`ACC_BIT_START]) begin
                start_next = 1'b1;
            end
        end
        if (sfr_wr && hit(sfr_addr, `ACC_OFS_CLKDIV)) begin
            div_next = sfr_wdata & `ACC_DIV_MASK;
        end
        // Completion wins over a same-cycle software clear of the flag.
        if (sq.finish) begin
            res_next = sq.result;
            ctrl_next[`ACC_BIT_START] = 1'b0;
            ctrl_next[`ACC_BIT_IDLE]  = 1'b0;
            ctrl_next[`ACC_BIT_DONE]  = 1'b1;
        end
    end

    // Read mux, interrupt level and the core suspend level.
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            if (hit(sfr_addr, `ACC_OFS_CONTROL)) begin
                rdata_next = ctrl_reg;
            end else if (hit(sfr_addr, `ACC_OFS_CLKDIV)) begin
                rdata_next = div_reg;
            end else if (hit(sfr_addr, `ACC_OFS_RES_LO)) begin
                rdata_next = {6'h00, res_reg[1:0]};
            end else if (hit(sfr_addr, `ACC_OFS_RES_HI)) begin
                rdata_next = res_reg[9:2];
            end else begin
                rdata_next = 8'h00;
            end
        end
        irq_next = ctrl_next[`ACC_BIT_DONE] & converter_interrupt_enable;
        // Registered so the core sees a flop, not a glitching gate.
        suspend_next = ctrl_next[`ACC_BIT_IDLE]
                     & ctrl_next[`ACC_BIT_START];
    end

    // State registers; reset clears all seven registers.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_reg  <= `ACC_RESET_VAL;
            div_reg   <= `ACC_RESET_VAL;
            res_reg   <= '0;
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
            start_reg <= 1'b0;
            suspend_reg <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg  <= ctrl_next;
            div_reg   <= div_next;
            res_reg   <= res_next;
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
            start_reg <= start_next;
            suspend_reg <= suspend_next;
        end
    end

    // Outputs straight from flip-flops.
    assign sfr_rdata        = rdata_reg;
    assign conversion_irq   = irq_reg;
    assign converter_enable = ctrl_reg[`ACC_BIT_ENABLE];
    assign channel_select   = ctrl_reg[`ACC_BIT_CHAN];
    assign sample_start     = start_reg;
    // Suspend only while converting, never merely because the bit is set.
    assign cpu_suspend      = suspend_reg;
endmodule : acc_top

/* File: logic/acc_defs.svh */
// Register offsets, field positions, reset values and timing counts for the
// converter control block. Assumes inclusion by bare name from logic/.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_OFS_CLKDIV  8'hf2
`define ACC_OFS_CONTROL 8'hf3
`define ACC_OFS_RES_LO  8'hf4
`define ACC_OFS_RES_HI  8'hf5
`define ACC_BIT_IDLE    6
`define ACC_BIT_ENABLE  5
`define ACC_BIT_DONE    4
`define ACC_BIT_START   3
`define ACC_BIT_CHAN    0
`define ACC_CTRL_MASK   8'h79
`define ACC_DIV_MASK    8'h1f
`define ACC_RESET_VAL   8'h00
`define ACC_CONV_CLOCKS 4'hb
`define ACC_RES_BITS    10
`endif

/* File: logic/acc_pkg.sv */
// Types shared by the converter control block and its sequencer.
// Assumes acc_defs.svh is on the include path.
`include "acc_defs.svh"
package acc_pkg;
    typedef logic [7:0] acc_byte_t;
    typedef logic [`ACC_RES_BITS-1:0] acc_result_t;
    typedef enum logic [1:0] {ACC_IDLE, ACC_RUN, ACC_DONE} acc_state_t;
endpackage : acc_pkg

/* File: logic/acc_seq_if.sv */
// Handshake carrying a conversion request and its completion between the
// register file and the sequencer. Single clock domain.
interface acc_seq_if;
    import acc_pkg::*;
    logic        launch;
    logic [4:0]  divider;
    logic        finish;
    acc_result_t result;
    modport regs (output launch, output divider, input finish, input result);
    modport seq  (input launch, input divider, output finish, output result);
endinterface : acc_seq_if

/* File: logic/acc_seq.sv */
// Conversion sequencer: derives the converter clock tick from the divider
// and counts converter clock periods until the result is ready.
// Assumes the analog core presents a stable result when finish is raised.
module acc_seq
    import acc_pkg::*;
(
    // Clocking.
    input  wire logic          sys_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    // Link to the register file.
    acc_seq_if.seq             sq,
    // Analog core result, already synchronised.
    input  wire acc_result_t   core_result
);
    logic [5:0] div_reg, div_next;
    logic [3:0] per_reg, per_next;
    acc_state_t st_reg, st_next;

    // Factor of zero stands for thirty-two so the full range is usable.
    function automatic logic [5:0] div_factor(input logic [4:0] d);
        div_factor = (d == 5'h00) ? 6'h20 : {1'b0, d};
    endfunction : div_factor

    // Next-state logic for the divider and the period counter.
    always_comb begin
        div_next = div_reg;
        per_next = per_reg;
        st_next  = st_reg;
        case (st_reg)
            ACC_IDLE: begin
                div_next = 6'h00;
                per_next = 4'h0;
                if (sq.launch) begin
                    st_next = ACC_RUN;
                end
            end
            ACC_RUN: begin
                if (div_reg + 6'h01 >= div_factor(sq.divider)) begin
                    div_next = 6'h00;
                    per_next = per_reg + 4'h1;
                    if (per_reg + 4'h1 == `ACC_CONV_CLOCKS) begin
                        st_next = ACC_DONE;
                    end
                end else begin
                    div_next = div_reg + 6'h01;
                end
            end
            ACC_DONE: st_next = ACC_IDLE;
            default:  st_next = ACC_IDLE;
        endcase
    end

    // Registers only; the clock enable freezes everything.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_reg <= 6'h00;
            per_reg <= 4'h0;
            st_reg  <= ACC_IDLE;
        end else if (clk_en) begin
            div_reg <= div_next;
            per_reg <= per_next;
            st_reg  <= st_next;
        end
    end

    assign sq.finish = (st_reg == ACC_DONE);
    assign sq.result = core_result;
endmodule : acc_seq

/* File: tb/acc_sva.sv */
// Checker for the register port and the core-side outputs.
// Assumes clk_en is high around register accesses; bound into acc_top.
module acc_sva
    import acc_pkg::*;
(
    // Clocking.
    input wire logic      sys_clk,
    input wire logic      srst,
    // Register port.
    input wire logic [7:0] sfr_addr,
    input wire acc_byte_t sfr_wdata,
    input wire logic      sfr_wr,
    input wire logic      sfr_rd,
    input wire acc_byte_t sfr_rdata,
    // Core side.
    input wire logic      converter_interrupt_enable,
    input wire logic      converter_enable,
    input wire logic      channel_select,
    input wire logic      sample_start,
    input wire logic      cpu_suspend,
    input wire logic      conversion_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Decoded accesses, shared by several properties.
    wire rd_lo = sfr_rd && sfr_addr < 8'hf2;
    wire rd_hi = sfr_rd && sfr_addr > 8'hf5;
    wire wr_ct = sfr_wr && sfr_addr == 8'hf3;
    a_reset_clear: assert property (disable iff (1'b0) srst |=>
        !(sample_start | cpu_suspend | conversion_irq))
        else $error("output set after reset");
    a_unmapped_zero: assert property ((rd_lo || rd_hi) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (
        sfr_rd && sfr_addr == 8'hf3 |=> (sfr_rdata & 8'h86) == 8'h00)
        else $error("control reserved bit set");
    a_div_reserved: assert property (
        sfr_rd && sfr_addr == 8'hf2 |=> sfr_rdata[7:5] == 3'h0)
        else $error("divider reserved bit set");
    a_low_reserved: assert property (
        sfr_rd && sfr_addr == 8'hf4 |=> sfr_rdata[7:2] == 6'h00)
        else $error("low result upper bits set");
    a_chan_follows: assert property (
        wr_ct |=> channel_select == $past(sfr_wdata[0]))
        else $error("channel select not taken");
    a_enable_follows: assert property (
        wr_ct |=> converter_enable == $past(sfr_wdata[5]))
        else $error("converter enable not taken");
    a_launch_cause: assert property (
        sample_start |-> $past(wr_ct && sfr_wdata[3]) ##1 !sample_start)
        else $error("launch without start write");
    a_no_relaunch: assert property (
        sample_start |-> !$past(cpu_suspend))
        else $error("start taken while running");
    a_irq_enable: assert property (
        conversion_irq |-> $past(converter_interrupt_enable))
        else $error("interrupt while disabled");
    // Main scenarios reached by the bench.
    c_launch: cover property (sample_start && cpu_suspend);
    c_refused: cover property (wr_ct && cpu_suspend);
    c_irq: cover property (conversion_irq);
endmodule : acc_sva

/* File: tb/acc_core_model.sv */
// Behavioural analog core: the held sample settles when a launch is seen.
// Assumes the register block's clock; levels arrive already quantised.
module acc_core_model
    import acc_pkg::*;
(
    // Clocking.
    input  wire logic        sys_clk,
    // Controls from the register block.
    input  wire logic        converter_enable,
    input  wire logic        channel_select,
    input  wire logic        sample_start,
    // Quantised input levels.
    input  wire acc_result_t analog_zero,
    input  wire acc_result_t analog_one,
    // Result lines.
    output acc_result_t      core_result_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // In standby the lines wander, so a result taken without a conversion
    // cannot look plausible.
    always @(posedge sys_clk) begin
        if (!converter_enable)
            core_result_pin <= ~core_result_pin;
        else if (sample_start)
            core_result_pin <= channel_select ? analog_zero : analog_one;
    end
endmodule : acc_core_model

/* File: tb/tb.sv */
// Self-checking bench: random conversions through the register port.
// Assumes the core model and checker are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import acc_pkg::*;
    logic        sys_clk, srst, sfr_wr, sfr_rd, ie, en, cs, st, sus, irq, ch;
    logic        ce;
    logic [7:0]  sfr_addr;
    logic [4:0]  dv;
    acc_byte_t   sfr_wdata, sfr_rdata;
    acc_result_t pin, a0, a1, ev;
    int          bad_count, check_count, n, f;
    acc_top dut (.sys_clk(sys_clk), .srst(srst), .clk_en(ce),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .converter_interrupt_enable(ie), .core_result_pin(pin),
        .converter_enable(en), .channel_select(cs), .sample_start(st),
        .cpu_suspend(sus), .conversion_irq(irq));
    acc_core_model core (.sys_clk(sys_clk), .converter_enable(en),
        .channel_select(cs), .sample_start(st), .analog_zero(a0),
        .analog_one(a1), .core_result_pin(pin));
    // Byte and flag comparison; flags travel packed into a byte.
    task automatic chk(input acc_byte_t g, input acc_byte_t e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input acc_byte_t d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr    <= 1'b0;
    endtask : wr
    // Read; data is taken a full cycle late since it holds until next read.
    task automatic rd(input logic [7:0] a, input acc_byte_t e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd   <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(sfr_rdata, e);
    endtask : rd
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // Clock and watchdog; the run is six conversions of 11 periods, each period at most 32 cycles.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
    initial begin
        {srst, sfr_wr, sfr_rd, ie, ce} = 5'b10001;
        {sfr_addr, sfr_wdata, a0, a1} = 36'h0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(32'hf4d3));
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values, then one unmapped place.
        for (int i = 0; i < 5; i++) rd(8'hf2 + 8'(i), 8'h00);
        // Divider corners 0 and 31 first, then random conversions.
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            dv = (i < 2) ? 5'(i * 31) : 5'($urandom_range(1, 5));
            ch = 1'($urandom);
            ie <= 1'($urandom);
            a0 <= 10'($urandom);
            a1 <= 10'($urandom);
            f = (dv == 5'h00) ? 32 : int'(dv);
            wr(8'hf2, {3'h0, dv});
            rd(8'hf2, {3'h0, dv});
            wr(8'hf3, {7'h34, ch});
            n = 0;
            // A repeated start write lands three cycles into the run, then
            // a two-cycle freeze must stretch the run by exactly two.
            do begin
                @(posedge sys_clk);
                sfr_wr <= (n == 3);
                ce     <= (n != 5 && n != 6);
                @(negedge sys_clk);
                n++;
            end while ((sus !== 1'b0 || n < 4) && n < 400);
            // One launch cycle, eleven periods, one done cycle and two frozen cycles.
            chk({7'h0, n == 11 * f + 4}, 8'h01);
            ev = ch ? a0 : a1;
            rd(8'hf3, {7'h18, ch});
            rd(8'hf5, ev[9:2]);
            rd(8'hf4, {6'h00, ev[1:0]});
            chk({5'h0, en, irq, cs}, {5'h0, 1'b1, ie, ch});
            wr(8'hf3, {7'h10, ch});
            rd(8'hf3, {7'h10, ch});
        end
        wr(8'hf3, 8'h00);
        @(negedge sys_clk);
        chk({7'h0, en}, 8'h00);
        summarize();
    end
endmodule : tb
bind acc_top acc_sva u_sva (
    .sys_clk                    (sys_clk),
    .srst                       (srst),
    .sfr_addr                   (sfr_addr),
    .sfr_wdata                  (sfr_wdata),
    .sfr_wr                     (sfr_wr),
    .sfr_rd                     (sfr_rd),
    .sfr_rdata                  (sfr_rdata),
    .converter_interrupt_enable (converter_interrupt_enable),
    .converter_enable           (converter_enable),
    .channel_select             (channel_select),
    .sample_start               (sample_start),
    .cpu_suspend                (cpu_suspend),
    .conversion_irq             (conversion_irq)
);
